// ### core/jrbp_defines.vh
// Shared constants for the jog, registration and assembled move profiler.
`ifndef JRBP_DEFINES_VH
`define JRBP_DEFINES_VH
// =============================================================
// Profile states
`define JRBP_S_IDLE 3'h0
`define JRBP_S_RUN 3'h1
`define JRBP_S_STOP 3'h2
`define JRBP_S_TRAIL 3'h3
`define JRBP_S_SEG 3'h4
`define JRBP_S_DWELL 3'h5
// =============================================================
// Move kinds
`define JRBP_K_JOG 2'h0
`define JRBP_K_REG 2'h1
`define JRBP_K_BLEND 2'h2
`define JRBP_K_DWELL 2'h3
// =============================================================
// Start command bit positions
`define JRBP_C_JOG_CW 0
`define JRBP_C_JOG_CCW 1
`define JRBP_C_REG_CW 2
`define JRBP_C_REG_CCW 3
`define JRBP_C_BLEND_CW 4
`define JRBP_C_BLEND_CCW 5
`define JRBP_C_DWELL 6
// =============================================================
// Timing
`define JRBP_CLK_PERIOD_PS 32'h00000FA0
`define JRBP_PS_PER_US 32'h000F4240
`define JRBP_CYC_PER_US (`JRBP_PS_PER_US / `JRBP_CLK_PERIOD_PS)
// =============================================================
// Segment count limits
`define JRBP_SEG_MIN 5'h02
`endif

// ### core/jrbp_step_gen.v
// Phase accumulator step generator.
`timescale 1ns/100ps
module jrbp_step_gen #(
  parameter ACC_W = 32,
  parameter SPD_W = 24
) (
  input wire clk,
  input wire sys_rst,
  input wire run,
  input wire [SPD_W-1:0] rate,
  output reg step_ff
);
  reg [ACC_W-1:0] acc_ff;
  wire [ACC_W:0] nxt_acc;

  // A step is one carry out of the accumulator, so the step rate tracks rate.
  assign nxt_acc = {1'b0, acc_ff} + {{(ACC_W + 1 - SPD_W){1'b0}}, rate};

  always @(posedge clk) begin
    if (sys_rst || !run) begin
      acc_ff <= {ACC_W{1'b0}};
      step_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc[ACC_W-1:0];
      step_ff <= nxt_acc[ACC_W];
    end
  end
endmodule

// ### core/jrbp_profiler.v
// Stepper motion profiler for jog, registration, blend and dwell moves.
`timescale 1ns/100ps
`include "jrbp_defines.vh"
module jrbp_profiler #(
  parameter SPD_W = 24,
  parameter CNT_W = 24,
  parameter POS_W = 32,
  parameter SEGS = 16,
  parameter IDX_W = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire jog_cw,
  input wire jog_ccw,
  input wire reg_cw,
  input wire reg_ccw,
  input wire blend_cw,
  input wire blend_ccw,
  input wire dwell_go,
  input wire hold_move,
  input wire abrupt_halt,
  input wire stop_in,
  input wire estop_in,
  input wire limit_cw,
  input wire limit_ccw,
  input wire clear_faults,
  input wire preset_pos,
  input wire [POS_W-1:0] preset_val,
  input wire [SPD_W-1:0] start_speed,
  input wire [SPD_W-1:0] prog_speed,
  input wire [SPD_W-1:0] accel,
  input wire [SPD_W-1:0] decel,
  input wire [CNT_W-1:0] trail_steps,
  input wire [CNT_W-1:0] min_dist,
  input wire [15:0] dwell_us,
  input wire [IDX_W:0] seg_count,
  input wire seg_wr,
  input wire [IDX_W-1:0] seg_idx,
  input wire [CNT_W:0] seg_dist,
  input wire [SPD_W-1:0] seg_speed,
  input wire [SPD_W-1:0] seg_acc,
  input wire [SPD_W-1:0] seg_dec,
  output reg step_ff,
  output reg dir_cw_ff,
  output reg [POS_W-1:0] position_ff,
  output reg pos_valid_ff,
  output reg busy_ff,
  output reg [SPD_W-1:0] speed_ff,
  output reg cw_blocked_ff,
  output reg ccw_blocked_ff,
  output reg cmd_error_ff
);
  // =============================================================
  // State
  reg [2:0] state_ff;
  reg [1:0] kind_ff;
  reg [SPD_W-1:0] target_ff;
  reg [SPD_W-1:0] acc_ff;
  reg [SPD_W-1:0] dec_ff;
  reg [CNT_W-1:0] remain_ff;
  reg [CNT_W-1:0] travel_ff;
  reg [CNT_W-1:0] min_ff;
  reg [CNT_W-1:0] trail_ff;
  reg [IDX_W-1:0] seg_ff;
  reg [IDX_W-1:0] last_ff;
  reg [31:0] dwell_cyc_ff;
  reg [31:0] dwell_cnt_ff;
  reg [6:0] cmd_q_ff;
  reg hold_q_ff;
  reg halt_q_ff;
  reg estop_q_ff;
  reg stop_q_ff;
  reg lim_cw_q_ff;
  reg lim_ccw_q_ff;
  reg [CNT_W:0] sd_mem [0:SEGS-1];
  reg [SPD_W-1:0] ss_mem [0:SEGS-1];
  reg [SPD_W-1:0] sa_mem [0:SEGS-1];
  reg [SPD_W-1:0] sdc_mem [0:SEGS-1];
  reg [SPD_W-1:0] nxt_speed;
  reg [SPD_W:0] nxt_sum;
  reg [SPD_W-1:0] nxt_tgt;

  // =============================================================
  // Edges and conditions
  wire gen_step;
  wire [6:0] cmd_w = {dwell_go, blend_ccw, blend_cw, reg_ccw, reg_cw, jog_ccw, jog_cw};
  wire [6:0] cmd_rise = cmd_w & ~cmd_q_ff;
  wire hold_tgl = hold_move ^ hold_q_ff;
  wire halt_rise = abrupt_halt & ~halt_q_ff;
  wire estop_rise = estop_in & ~estop_q_ff;
  wire stop_rise = stop_in & ~stop_q_ff;
  wire lim_fwd = dir_cw_ff ? limit_cw : limit_ccw;
  wire lim_back = dir_cw_ff ? (limit_ccw & ~lim_ccw_q_ff) : (limit_cw & ~lim_cw_q_ff);
  wire ok_cw = ~limit_cw & ~cw_blocked_ff;
  wire ok_ccw = ~limit_ccw & ~ccw_blocked_ff;
  wire moving = (state_ff != `JRBP_S_IDLE) && (state_ff != `JRBP_S_DWELL);
  wire cmd_lvl = (kind_ff == `JRBP_K_JOG) ? (dir_cw_ff ? jog_cw : jog_ccw) : (dir_cw_ff ? reg_cw : reg_ccw);
  wire abrupt = (state_ff != `JRBP_S_IDLE) && (halt_rise || estop_rise || (moving && (lim_fwd || lim_back)));
  wire last_seg = (seg_ff == last_ff);
  wire [IDX_W-1:0] nseg = seg_ff + {{(IDX_W - 1){1'b0}}, 1'b1};
  wire [SPD_W-1:0] span = (speed_ff > start_speed) ? (speed_ff - start_speed) : {SPD_W{1'b0}};
  wire [CNT_W+SPD_W-1:0] ramp_need = remain_ff * dec_ff;
  wire closing = (state_ff == `JRBP_S_TRAIL) ||
    ((state_ff == `JRBP_S_SEG) && (last_seg || (kind_ff == `JRBP_K_DWELL)));
  wire ramp_down = closing && (ramp_need <= {{CNT_W{1'b0}}, span});
  wire [CNT_W:0] d0 = sd_mem[0];
  wire [31:0] dwell_prod = {16'h0000, dwell_us} * `JRBP_CYC_PER_US;

  // =============================================================
  // Speed ramp, one update per step
  always @* begin
    nxt_tgt = ramp_down ? start_speed : target_ff;
    nxt_sum = {1'b0, speed_ff} + {1'b0, acc_ff};
    nxt_speed = speed_ff;
    if (speed_ff < nxt_tgt) begin
      nxt_speed = (nxt_sum > {1'b0, nxt_tgt}) ? nxt_tgt : nxt_sum[SPD_W-1:0];
    end else if (speed_ff > nxt_tgt) begin
      nxt_speed = ((speed_ff - nxt_tgt) < dec_ff) ? nxt_tgt : (speed_ff - dec_ff);
    end
  end

  jrbp_step_gen #(
    .ACC_W(32),
    .SPD_W(SPD_W)
  ) u_step (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(moving),
    .rate(speed_ff),
    .step_ff(gen_step)
  );

  // =============================================================
  // Segment table
  always @(posedge clk) begin
    if (seg_wr) begin
      sd_mem[seg_idx] <= seg_dist;
      ss_mem[seg_idx] <= seg_speed;
      sa_mem[seg_idx] <= seg_acc;
      sdc_mem[seg_idx] <= seg_dec;
    end
  end

  task load_seg;
    input [IDX_W-1:0] idx;
    input dwell;
    reg [CNT_W:0] d;
    begin
      d = sd_mem[idx];
      remain_ff <= d[CNT_W] ? (~d[CNT_W-1:0] + {{(CNT_W - 1){1'b0}}, 1'b1}) : d[CNT_W-1:0];
      target_ff <= ss_mem[idx];
      acc_ff <= sa_mem[idx];
      dec_ff <= sdc_mem[idx];
      seg_ff <= idx;
      if (dwell) begin
        dir_cw_ff <= ~d[CNT_W];
      end
    end
  endtask

  // =============================================================
  // Move sequencer
  always @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= `JRBP_S_IDLE;
      kind_ff <= `JRBP_K_JOG;
      dir_cw_ff <= 1'b1;
      speed_ff <= {SPD_W{1'b0}};
      target_ff <= {SPD_W{1'b0}};
      acc_ff <= {SPD_W{1'b0}};
      dec_ff <= {SPD_W{1'b0}};
      remain_ff <= {CNT_W{1'b0}};
      travel_ff <= {CNT_W{1'b0}};
      min_ff <= {CNT_W{1'b0}};
      trail_ff <= {CNT_W{1'b0}};
      seg_ff <= {IDX_W{1'b0}};
      last_ff <= {IDX_W{1'b0}};
      dwell_cyc_ff <= 32'h00000000;
      dwell_cnt_ff <= 32'h00000000;
      cmd_q_ff <= 7'h7F;
      hold_q_ff <= 1'b0;
      halt_q_ff <= 1'b1;
      estop_q_ff <= 1'b1;
      stop_q_ff <= 1'b1;
      lim_cw_q_ff <= 1'b1;
      lim_ccw_q_ff <= 1'b1;
      step_ff <= 1'b0;
      position_ff <= {POS_W{1'b0}};
      pos_valid_ff <= 1'b0;
      busy_ff <= 1'b0;
      cw_blocked_ff <= 1'b0;
      ccw_blocked_ff <= 1'b0;
      cmd_error_ff <= 1'b0;
    end else begin
      cmd_q_ff <= cmd_w;
      hold_q_ff <= hold_move;
      halt_q_ff <= abrupt_halt;
      estop_q_ff <= estop_in;
      stop_q_ff <= stop_in;
      lim_cw_q_ff <= limit_cw;
      lim_ccw_q_ff <= limit_ccw;
      busy_ff <= (state_ff != `JRBP_S_IDLE);
      step_ff <= 1'b0;
      if (clear_faults) begin
        cw_blocked_ff <= 1'b0;
        ccw_blocked_ff <= 1'b0;
        cmd_error_ff <= 1'b0;
      end
      if (preset_pos && (state_ff == `JRBP_S_IDLE)) begin
        position_ff <= preset_val;
        pos_valid_ff <= 1'b1;
      end
      // Steps and per-step speed update.
      if (gen_step && moving && !abrupt) begin
        step_ff <= 1'b1;
        speed_ff <= nxt_speed;
        position_ff <= dir_cw_ff ? (position_ff + {{(POS_W - 1){1'b0}}, 1'b1})
          : (position_ff - {{(POS_W - 1){1'b0}}, 1'b1});
        if (travel_ff != {CNT_W{1'b1}}) begin
          travel_ff <= travel_ff + {{(CNT_W - 1){1'b0}}, 1'b1};
        end
      end
      case (state_ff)
        `JRBP_S_IDLE: begin
          travel_ff <= {CNT_W{1'b0}};
          speed_ff <= start_speed;
          target_ff <= (prog_speed < start_speed) ? start_speed : prog_speed;
          acc_ff <= accel;
          dec_ff <= decel;
          min_ff <= min_dist;
          trail_ff <= trail_steps;
          dwell_cyc_ff <= dwell_prod;
          last_ff <= seg_count[IDX_W-1:0] - {{(IDX_W - 1){1'b0}}, 1'b1};
          if ((cmd_rise[`JRBP_C_JOG_CW] && ok_cw) || (cmd_rise[`JRBP_C_REG_CW] && ok_cw)) begin
            state_ff <= `JRBP_S_RUN;
            kind_ff <= cmd_rise[`JRBP_C_JOG_CW] ? `JRBP_K_JOG : `JRBP_K_REG;
            dir_cw_ff <= 1'b1;
          end else if ((cmd_rise[`JRBP_C_JOG_CCW] || cmd_rise[`JRBP_C_REG_CCW]) && ok_ccw) begin
            state_ff <= `JRBP_S_RUN;
            kind_ff <= cmd_rise[`JRBP_C_JOG_CCW] ? `JRBP_K_JOG : `JRBP_K_REG;
            dir_cw_ff <= 1'b0;
          end else if (cmd_rise[`JRBP_C_BLEND_CW] || cmd_rise[`JRBP_C_BLEND_CCW] || cmd_rise[`JRBP_C_DWELL]) begin
            if (seg_count < `JRBP_SEG_MIN || seg_count > SEGS) begin
              cmd_error_ff <= 1'b1;
            end else if (cmd_rise[`JRBP_C_DWELL]) begin
              if (d0[CNT_W] ? ok_ccw : ok_cw) begin
                state_ff <= `JRBP_S_SEG;
                kind_ff <= `JRBP_K_DWELL;
                load_seg({IDX_W{1'b0}}, 1'b1);
              end
            end else if (cmd_rise[`JRBP_C_BLEND_CW] ? ok_cw : ok_ccw) begin
              state_ff <= `JRBP_S_SEG;
              kind_ff <= `JRBP_K_BLEND;
              dir_cw_ff <= cmd_rise[`JRBP_C_BLEND_CW];
              load_seg({IDX_W{1'b0}}, 1'b0);
            end
          end
        end
        `JRBP_S_RUN: begin
          if (kind_ff == `JRBP_K_JOG) begin
            acc_ff <= accel;
            dec_ff <= decel;
            if (prog_speed >= start_speed) begin
              target_ff <= prog_speed;
            end
            if (!cmd_lvl || stop_rise || hold_tgl) begin
              state_ff <= `JRBP_S_STOP;
              target_ff <= start_speed;
            end
          end else if (hold_tgl) begin
            state_ff <= `JRBP_S_STOP;
            target_ff <= start_speed;
          end else if ((!cmd_lvl || stop_in) && travel_ff >= min_ff) begin
            remain_ff <= trail_ff;
            state_ff <= (trail_ff == {CNT_W{1'b0}}) ? `JRBP_S_IDLE : `JRBP_S_TRAIL;
          end
        end
        `JRBP_S_STOP: begin
          if (gen_step && speed_ff <= start_speed) begin
            state_ff <= `JRBP_S_IDLE;
          end
        end
        `JRBP_S_TRAIL: begin
          if (gen_step) begin
            remain_ff <= remain_ff - {{(CNT_W - 1){1'b0}}, 1'b1};
            if (remain_ff <= {{(CNT_W - 1){1'b0}}, 1'b1}) begin
              state_ff <= `JRBP_S_IDLE;
            end
          end
        end
        `JRBP_S_SEG: begin
          if (hold_tgl) begin
            state_ff <= `JRBP_S_STOP;
            target_ff <= start_speed;
          end else if (gen_step) begin
            remain_ff <= remain_ff - {{(CNT_W - 1){1'b0}}, 1'b1};
            if (remain_ff <= {{(CNT_W - 1){1'b0}}, 1'b1}) begin
              if (last_seg) begin
                state_ff <= `JRBP_S_IDLE;
              end else if (kind_ff == `JRBP_K_DWELL) begin
                state_ff <= `JRBP_S_DWELL;
                dwell_cnt_ff <= dwell_cyc_ff;
              end else begin
                load_seg(nseg, 1'b0);
                if (speed_ff != target_ff) begin
                  speed_ff <= ss_mem[nseg];
                end
              end
            end
          end
        end
        `JRBP_S_DWELL: begin
          if (hold_tgl) begin
            state_ff <= `JRBP_S_IDLE;
          end else if (dwell_cnt_ff == 32'h00000000) begin
            state_ff <= `JRBP_S_SEG;
            speed_ff <= start_speed;
            load_seg(nseg, 1'b1);
          end else begin
            dwell_cnt_ff <= dwell_cnt_ff - 32'h00000001;
          end
        end
        default: begin
          state_ff <= `JRBP_S_IDLE;
        end
      endcase
      // Abrupt stop overrides the next state chosen above.
      if (abrupt) begin
        state_ff <= `JRBP_S_IDLE;
        pos_valid_ff <= 1'b0;
        if (moving && lim_fwd) begin
          if (dir_cw_ff) begin
            cw_blocked_ff <= 1'b1;
          end else begin
            ccw_blocked_ff <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### sim/jrbp_host_model.sv
// Host model that loads the assembled move segment table.
`timescale 1ns/100ps
module jrbp_host_model (
  input wire clk,
  input wire load,
  output reg seg_wr_ff = 1'b0,
  output reg [3:0] seg_idx_ff = 4'h0,
  output reg [24:0] seg_dist_ff = 25'h0000000,
  output reg [23:0] seg_speed_ff = 24'h000000,
  output reg done_ff = 1'b0
);
  reg [1:0] cnt_ff = 2'h0;
  // =====================================================
  // Segment writes
  // Segments of +3, -2 and +4 steps; idle data lines do not keep the last value.
  always @(posedge clk) begin
    seg_wr_ff <= 1'b0;
    seg_dist_ff <= ~seg_dist_ff;
    seg_speed_ff <= ~seg_speed_ff;
    if (load && !done_ff) begin
      seg_wr_ff <= 1'b1;
      seg_idx_ff <= {2'h0, cnt_ff};
      seg_dist_ff <= (cnt_ff == 2'h0) ? 25'h0000003 : (cnt_ff == 2'h1) ? 25'h1FFFFFE : 25'h0000004;
      seg_speed_ff <= 24'hC00000 + {2'h0, cnt_ff, 20'h00000};
      cnt_ff <= cnt_ff + 2'h1;
      done_ff <= (cnt_ff == 2'h2);
    end
  end
endmodule

// ### sim/jrbp_profiler_monitor.sv
// Concurrent checks on the profiler ports.
`timescale 1ns/100ps
module jrbp_profiler_monitor #(
  parameter POS_W = 32
) (
  input wire clk,
  input wire sys_rst,
  input wire abrupt_halt,
  input wire estop_in,
  input wire limit_cw,
  input wire limit_ccw,
  input wire step_ff,
  input wire dir_cw_ff,
  input wire [POS_W-1:0] position_ff,
  input wire pos_valid_ff,
  input wire busy_ff,
  input wire cw_blocked_ff,
  input wire ccw_blocked_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // =====================================================
  // Shared sequences and properties
  sequence seq_abrupt_end;
    ##[1:2] (!busy_ff && !pos_valid_ff) ##1 !step_ff [*4];
  endsequence
  property p_pos_dir;
    busy_ff && $past(busy_ff) && position_ff != $past(position_ff)
      |-> position_ff == (dir_cw_ff ? $past(position_ff) + 1'b1 : $past(position_ff) - 1'b1);
  endproperty
  // =====================================================
  // Assertions
  a_step_single: assert property (step_ff |=> !step_ff)
    else $error("step pulse too long");
  a_idle_no_step: assert property (!busy_ff [*3] |-> !step_ff)
    else $error("step while idle");
  a_pos_follow_dir: assert property (p_pos_dir)
    else $error("position step wrong");
  a_halt_abrupt: assert property ($rose(abrupt_halt) && busy_ff |-> seq_abrupt_end)
    else $error("halt not abrupt");
  a_estop_abrupt: assert property ($rose(estop_in) && busy_ff |-> seq_abrupt_end)
    else $error("estop not abrupt");
  a_limit_cw_block: assert property (busy_ff && dir_cw_ff && $rose(limit_cw) |-> ##[1:2] cw_blocked_ff)
    else $error("cw limit not latched");
  a_limit_ccw_block: assert property (busy_ff && !dir_cw_ff && $rose(limit_ccw) |-> ##[1:2] ccw_blocked_ff)
    else $error("ccw limit not latched");
  a_start_away_cw: assert property ((!busy_ff && limit_cw) [*2] |=> !(busy_ff && dir_cw_ff))
    else $error("start into cw limit");
  a_start_away_ccw: assert property ((!busy_ff && limit_ccw) [*2] |=> !(busy_ff && !dir_cw_ff))
    else $error("start into ccw limit");
endmodule
bind jrbp_profiler jrbp_profiler_monitor #(.POS_W(POS_W)) u_mon (.clk(clk), .sys_rst(sys_rst),
  .abrupt_halt(abrupt_halt), .estop_in(estop_in), .limit_cw(limit_cw), .limit_ccw(limit_ccw),
  .step_ff(step_ff), .dir_cw_ff(dir_cw_ff), .position_ff(position_ff), .pos_valid_ff(pos_valid_ff),
  .busy_ff(busy_ff), .cw_blocked_ff(cw_blocked_ff), .ccw_blocked_ff(ccw_blocked_ff));

// ### sim/jrbp_profiler_tb.sv
// Self-checking bench for the stepper motion profiler.
`timescale 1ns/100ps
module jrbp_profiler_tb;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg jog_cw = 1'b0, jog_ccw = 1'b0, reg_cw = 1'b0, reg_ccw = 1'b0, blend_cw = 1'b0, blend_ccw = 1'b0;
  reg dwell_go = 1'b0, hold_move = 1'b0, abrupt_halt = 1'b0, stop_in = 1'b0, estop_in = 1'b0;
  reg limit_cw = 1'b0, limit_ccw = 1'b0, clear_faults = 1'b0, preset_pos = 1'b0, load = 1'b0;
  reg [31:0] preset_val = 32'h00000100;
  reg [23:0] start_speed = 24'h800000, prog_speed = 24'hC00000, acc = 24'h100000;
  reg [23:0] trail_steps = 24'h000002, min_dist = 24'h000003;
  reg [15:0] dwell_us = 16'h0001;
  reg [4:0] seg_count = 5'h03;
  wire seg_wr, done, step_ff, dir_cw_ff, pos_valid_ff, busy_ff, cw_blocked_ff, ccw_blocked_ff, cmd_error_ff;
  wire [3:0] seg_idx;
  wire [24:0] seg_dist;
  wire [23:0] seg_speed, speed_ff;
  wire [31:0] position_ff;
  integer errors = 0, checks = 0, d;
  reg [31:0] nsteps = 32'h00000000, p = 32'h00000000;
  jrbp_host_model host (.clk(clk), .load(load), .seg_wr_ff(seg_wr), .seg_idx_ff(seg_idx),
    .seg_dist_ff(seg_dist), .seg_speed_ff(seg_speed), .done_ff(done));
  jrbp_profiler dut (.clk(clk), .sys_rst(sys_rst), .jog_cw(jog_cw), .jog_ccw(jog_ccw), .reg_cw(reg_cw),
    .reg_ccw(reg_ccw), .blend_cw(blend_cw), .blend_ccw(blend_ccw), .dwell_go(dwell_go), .hold_move(hold_move),
    .abrupt_halt(abrupt_halt), .stop_in(stop_in), .estop_in(estop_in), .limit_cw(limit_cw),
    .limit_ccw(limit_ccw), .clear_faults(clear_faults), .preset_pos(preset_pos), .preset_val(preset_val),
    .start_speed(start_speed), .prog_speed(prog_speed), .accel(acc), .decel(acc), .trail_steps(trail_steps),
    .min_dist(min_dist), .dwell_us(dwell_us), .seg_count(seg_count), .seg_wr(seg_wr), .seg_idx(seg_idx),
    .seg_dist(seg_dist), .seg_speed(seg_speed), .seg_acc(acc), .seg_dec(acc), .step_ff(step_ff),
    .dir_cw_ff(dir_cw_ff), .position_ff(position_ff), .pos_valid_ff(pos_valid_ff), .busy_ff(busy_ff),
    .speed_ff(speed_ff), .cw_blocked_ff(cw_blocked_ff), .ccw_blocked_ff(ccw_blocked_ff),
    .cmd_error_ff(cmd_error_ff));
  always #2 clk = ~clk;
  always @(posedge clk) if (step_ff === 1'b1) nsteps <= nsteps + 32'h1;
  // =====================================================
  // Tasks
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk_word(input [8*12-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected %0s: expected %h, seen %h", name, exp, got);
      end
    end
  endtask
  task chk_bit(input [8*12-1:0] name, input exp, input got);
    chk_word(name, {31'h0, exp}, {31'h0, got});
  endtask
  task wait_steps(input [31:0] n);
    integer k;
    begin
      for (k = 0; k < 5000 && nsteps < n; k = k + 1) @(negedge clk);
      if (nsteps < n) begin
        errors = errors + 1;
        $display("unexpected step wait: expected %0d, seen %0d", n, nsteps);
      end
    end
  endtask
  task wait_idle;
    integer k;
    begin
      cyc(3);
      for (k = 0; k < 20000 && busy_ff !== 1'b0; k = k + 1) @(negedge clk);
      if (busy_ff !== 1'b0) begin
        errors = errors + 1;
        $display("unexpected idle wait: expected 0, seen %b", busy_ff);
      end
    end
  endtask
  task preset;
    begin
      preset_pos = 1'b1;
      cyc(1);
      preset_pos = 1'b0;
      cyc(1);
      p = preset_val;
      nsteps = 32'h0;
    end
  endtask
  task jog(input integer dd, input v);
    if (dd == 0) jog_cw = v; else jog_ccw = v;
  endtask
  task conclude;
    begin
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #300000;
    errors = errors + 1;
    conclude;
  end
  // =====================================================
  // Tests
  initial begin
    cyc(20);
    sys_rst = 1'b0;
    cyc(2);
    load = 1'b1;
    cyc(5);
    load = 1'b0;
    chk_bit("loaded", 1'b1, done);
    preset;
    jog_cw = 1'b1;
    cyc(2);
    chk_word("speed", {8'h00, start_speed}, {8'h00, speed_ff});
    wait_steps(6);
    chk_word("speed", 32'h00C00000, {8'h00, speed_ff});
    prog_speed = 24'h100000;
    wait_steps(9);
    chk_word("speed", 32'h00C00000, {8'h00, speed_ff});
    prog_speed = 24'hF00000;
    wait_steps(14);
    chk_word("speed", 32'h00F00000, {8'h00, speed_ff});
    jog_cw = 1'b0;
    wait_idle;
    chk_bit("valid", 1'b1, pos_valid_ff);
    chk_word("position", p + nsteps, position_ff);
    p = p + nsteps;
    nsteps = 32'h0;
    jog_ccw = 1'b1;
    wait_steps(3);
    stop_in = 1'b1;
    wait_idle;
    chk_bit("dir", 1'b0, dir_cw_ff);
    chk_word("position", p - nsteps, position_ff);
    chk_bit("valid", 1'b1, pos_valid_ff);
    stop_in = 1'b0;
    jog_ccw = 1'b0;
    for (d = 0; d < 2; d = d + 1) begin
      nsteps = 32'h0;
      jog(d, 1'b1);
      wait_steps(2);
      if (d == 0) limit_cw = 1'b1; else limit_ccw = 1'b1;
      wait_idle;
      chk_bit("blocked", 1'b1, d == 0 ? cw_blocked_ff : ccw_blocked_ff);
      chk_bit("valid", 1'b0, pos_valid_ff);
      jog(d, 1'b0);
      cyc(2);
      jog(d, 1'b1);
      cyc(8);
      chk_bit("busy", 1'b0, busy_ff);
      jog(d, 1'b0);
      preset;
      jog(1 - d, 1'b1);
      cyc(4);
      chk_bit("busy", 1'b1, busy_ff);
      if (d == 0) abrupt_halt = 1'b1; else estop_in = 1'b1;
      wait_idle;
      chk_bit("valid", 1'b0, pos_valid_ff);
      {abrupt_halt, estop_in, limit_cw, limit_ccw} = 4'h0;
      jog(1 - d, 1'b0);
      clear_faults = 1'b1;
      cyc(1);
      clear_faults = 1'b0;
      cyc(1);
      chk_bit("blocked", 1'b0, cw_blocked_ff | ccw_blocked_ff);
    end
    preset;
    stop_in = 1'b1;
    reg_cw = 1'b1;
    wait_idle;
    chk_word("reg steps", 32'h5, nsteps);
    chk_word("position", p + 32'h5, position_ff);
    stop_in = 1'b0;
    reg_cw = 1'b0;
    min_dist = 24'h000002;
    trail_steps = 24'h000004;
    cyc(2);
    nsteps = 32'h0;
    reg_cw = 1'b1;
    wait_steps(4);
    reg_cw = 1'b0;
    wait_idle;
    chk_word("reg steps", 32'h8, nsteps);
    trail_steps = 24'h000014;
    nsteps = 32'h0;
    reg_cw = 1'b1;
    wait_steps(3);
    hold_move = 1'b1;
    wait_idle;
    chk_bit("hold steps", 1'b1, nsteps < 32'h17);
    chk_bit("busy", 1'b0, busy_ff);
    reg_cw = 1'b0;
    seg_count = 5'h01;
    blend_cw = 1'b1;
    cyc(4);
    chk_bit("cmd error", 1'b1, cmd_error_ff);
    chk_bit("busy", 1'b0, busy_ff);
    blend_cw = 1'b0;
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    seg_count = 5'h03;
    preset;
    blend_ccw = 1'b1;
    wait_steps(3);
    chk_word("speed", 32'h00D00000, {8'h00, speed_ff});
    wait_idle;
    chk_word("blend steps", 32'h9, nsteps);
    chk_word("position", p - 32'h9, position_ff);
    nsteps = 32'h0;
    dwell_go = 1'b1;
    wait_idle;
    chk_word("dwell steps", 32'h9, nsteps);
    chk_word("position", p - 32'h4, position_ff);
    conclude;
  end
endmodule
